/* logic/seeadr_slave.v */
// Two-wire slave front end: START/STOP, slave address decode, array address, ack
`timescale 1ns/1ps
`include "seeadr_consts.vh"
module seeadr_slave #(
	parameter [3:0] TYPE_CODE   = 4'h5,
	parameter       PROG_CYCLES = `SEEADR_PROG_CYCLES
) (
	// Clock and control
	input  wire        CLK_IN,
	input  wire        SYS_RST_IN,
	input  wire        CE_IN,
	// Two-wire bus pins
	input  wire        SCL_IN,
	input  wire        SDA_IN,
	output wire        SDA_OUT,
	output wire        SDA_OE_OUT,
	// Strap pins
	input  wire        CHIP_SELECT_PIN_IN,
	input  wire        WP_IN,
	// Decoded request
	output reg  [16:0] ARRAY_ADDR_OUT,
	output reg         READ_REQ_OUT,
	output reg         ADDR_VALID_OUT,
	// Received write data stream
	output wire        WDATA_VALID_OUT,
	input  wire        WDATA_READY_IN,
	output wire [7:0]  WDATA_OUT,
	// Program cycle status
	output wire        PROG_BUSY_OUT
);
	reg [1:0]  scl_s_q;
	reg [1:0]  sda_s_q;
	reg [1:0]  cs_s_q;
	reg [1:0]  wp_s_q;
	reg        scl_q;
	reg        sda_q;
	reg [2:0]  st_q;
	reg [3:0]  bit_q;
	reg [7:0]  sh_q;
	reg        ack_q;
	reg        wr_seen_q;
	reg        rd_q;
	reg        top_q;
	reg [31:0] prog_q;
	reg        push_q;
	reg [7:0]  push_data_q;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_ev;
	wire       stop_ev;
	wire [7:0] byte_w;
	wire       buf_ready;
	wire       sel_match;

	// Timer is 32 bits wide; the reload is sized to match it
	localparam [31:0] PROG_LOAD = PROG_CYCLES;

	// Pins are asynchronous to CLK_IN: two stages before use
	// CE_IN low also freezes these stages, so pin edges in that window are seen late and pulses inside it are missed
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			cs_s_q  <= 2'h0;
			wp_s_q  <= 2'h0;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
		end else if (CE_IN) begin
			scl_s_q <= {scl_s_q[0], SCL_IN};
			sda_s_q <= {sda_s_q[0], SDA_IN};
			cs_s_q  <= {cs_s_q[0], CHIP_SELECT_PIN_IN};
			wp_s_q  <= {wp_s_q[0], WP_IN};
			scl_q   <= scl_s_q[1];
			sda_q   <= sda_s_q[1];
		end
	end

	assign scl_rise = scl_s_q[1] && !scl_q;
	assign scl_fall = !scl_s_q[1] && scl_q;
	// Data edges with clock high mark framing, not data
	assign start_ev = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1];
	assign stop_ev  = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1];
	assign byte_w   = {sh_q[6:0], sda_s_q[1]};

	// Type, constant zero and select pin must all agree
	// Decided at the eighth falling edge, when sh_q holds the whole byte
	assign sel_match = (sh_q[`SEEADR_TYPE_MSB:`SEEADR_TYPE_LSB] == TYPE_CODE) &&
		(sh_q[`SEEADR_BLK_HI_BIT] == `SEEADR_BLK_HI_VAL) &&
		(sh_q[`SEEADR_BLK_SEL_BIT] == cs_s_q[1]);

	assign PROG_BUSY_OUT = (prog_q != 32'h0000_0000);
	// Open drain: only ever drive low
	assign SDA_OUT    = 1'b0;
	assign SDA_OE_OUT = ack_q;

	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			st_q           <= `SEEADR_ST_IDLE;
			bit_q          <= 4'h0;
			sh_q           <= 8'h00;
			ack_q          <= 1'b0;
			wr_seen_q      <= 1'b0;
			rd_q           <= 1'b0;
			top_q          <= 1'b0;
			prog_q         <= 32'h0000_0000;
			push_q         <= 1'b0;
			push_data_q    <= 8'h00;
			ARRAY_ADDR_OUT <= 17'h0_0000;
			READ_REQ_OUT   <= 1'b0;
			ADDR_VALID_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (push_q && buf_ready)
				push_q <= 1'b0;
			if (prog_q != 32'h0000_0000)
				prog_q <= prog_q - 32'h0000_0001;
			if (start_ev) begin
				// A repeated START drops any address taken so far
				st_q           <= `SEEADR_ST_SLAVE;
				bit_q          <= 4'h0;
				ack_q          <= 1'b0;
				ADDR_VALID_OUT <= 1'b0;
			end else if (stop_ev) begin
				// Program cycle starts only if a write byte was really taken
				if (wr_seen_q)
					prog_q <= PROG_LOAD;
				wr_seen_q      <= 1'b0;
				st_q           <= `SEEADR_ST_IDLE;
				ack_q          <= 1'b0;
				ADDR_VALID_OUT <= 1'b0;
			end else if (st_q != `SEEADR_ST_IDLE && st_q != `SEEADR_ST_IGNORE) begin
				if (scl_rise && bit_q < 4'h8) begin
					sh_q  <= byte_w;
					bit_q <= bit_q + 4'h1;
				end else if (scl_fall && bit_q == 4'h8) begin
					bit_q <= 4'h9;
					case (st_q)
						`SEEADR_ST_SLAVE: begin
							if (sel_match && !PROG_BUSY_OUT) begin
								ack_q <= 1'b1;
								rd_q  <= (sh_q[`SEEADR_RW_BIT] == `SEEADR_RW_READ);
								top_q <= sh_q[`SEEADR_BLK_TOP_BIT];
							end else begin
								st_q <= `SEEADR_ST_IGNORE;
							end
						end
						`SEEADR_ST_ADDR_HI: begin
							ack_q                <= 1'b1;
							ARRAY_ADDR_OUT[16]   <= top_q;
							ARRAY_ADDR_OUT[15:8] <= sh_q;
						end
						`SEEADR_ST_ADDR_LO: begin
							ack_q               <= 1'b1;
							ARRAY_ADDR_OUT[7:0] <= sh_q;
							// Direction only: no read data is sent from this block
							READ_REQ_OUT        <= rd_q;
							ADDR_VALID_OUT      <= 1'b1;
						end
						`SEEADR_ST_DATA: begin
							// Protected or stalled data bytes get no acknowledge
							if (!wp_s_q[1] && !rd_q && !push_q) begin
								ack_q       <= 1'b1;
								push_q      <= 1'b1;
								push_data_q <= sh_q;
								wr_seen_q   <= 1'b1;
							end
						end
						default: begin
							st_q <= `SEEADR_ST_IGNORE;
						end
					endcase
				end else if (scl_fall && bit_q == 4'h9) begin
					// Release after the ninth clock
					ack_q <= 1'b0;
					bit_q <= 4'h0;
					case (st_q)
						`SEEADR_ST_SLAVE:   st_q <= `SEEADR_ST_ADDR_HI;
						`SEEADR_ST_ADDR_HI: st_q <= `SEEADR_ST_ADDR_LO;
						`SEEADR_ST_ADDR_LO: st_q <= `SEEADR_ST_DATA;
						default:            st_q <= st_q;
					endcase
				end
			end
		end
	end

	// Second entry lets a byte wait while the next one is shifted in
	seeadr_buf2 #(
		.WIDTH(8)
	) u_buf (
		.clk_in        (CLK_IN),
		.rst_in        (SYS_RST_IN),
		.ce_in         (CE_IN),
		.in_valid_in   (push_q),
		.in_ready_out  (buf_ready),
		.in_data_in    (push_data_q),
		.out_valid_out (WDATA_VALID_OUT),
		.out_ready_in  (WDATA_READY_IN),
		.out_data_out  (WDATA_OUT)
	);
endmodule // seeadr_slave

/* shared/seeadr_consts.vh */
// Constants for the serial EEPROM two-wire addressing front end
`ifndef SEEADR_CONSTS_VH
`define SEEADR_CONSTS_VH
`define SEEADR_TYPE_MSB       7
`define SEEADR_TYPE_LSB       4
`define SEEADR_BLK_HI_BIT     3
`define SEEADR_BLK_SEL_BIT    2
`define SEEADR_BLK_TOP_BIT    1
`define SEEADR_RW_BIT         0
`define SEEADR_BLK_HI_VAL     1'b0
`define SEEADR_RW_READ        1'b1
`define SEEADR_ADDR_W         17
`define SEEADR_PROG_TIME_MS   10
`define SEEADR_CLK_MHZ        100
`define SEEADR_PROG_CYCLES    (`SEEADR_PROG_TIME_MS * 1000 * `SEEADR_CLK_MHZ)
`define SEEADR_ST_IDLE        3'h0
`define SEEADR_ST_SLAVE       3'h1
`define SEEADR_ST_ADDR_HI     3'h2
`define SEEADR_ST_ADDR_LO     3'h3
`define SEEADR_ST_DATA        3'h4
`define SEEADR_ST_IGNORE      3'h5
`endif

/* logic/seeadr_buf2.v */
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module seeadr_buf2 #(
	parameter WIDTH = 8
) (
	input  wire             clk_in,
	input  wire             rst_in,
	input  wire             ce_in,
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem_q [0:1];
	reg             wp_q;
	reg             rp_q;
	reg [1:0]       cnt_q;
	wire            push;
	wire            pop;

	assign in_ready_out  = (cnt_q != 2'h2);
	assign out_valid_out = (cnt_q != 2'h0);
	assign out_data_out  = mem_q[rp_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always @(posedge clk_in) begin
		if (rst_in) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else if (ce_in) begin
			if (push) begin
				mem_q[wp_q] <= in_data_in;
				wp_q        <= ~wp_q;
			end
			if (pop)
				rp_q <= ~rp_q;
			if (push && !pop)
				cnt_q <= cnt_q + 2'h1;
			else if (pop && !push)
				cnt_q <= cnt_q - 2'h1;
		end
	end
endmodule // seeadr_buf2

/* test/seeadr_master.sv */
// Behavioural two-wire bus master
`timescale 1ns/1ps
module seeadr_master (
	input  wire clk_in,
	input  wire sda_in,
	output reg  scl_out,
	output reg  sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task w(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Data moves only while the clock is low
	task bit_io(input v, output s);
		w(3);
		sda_low_out = !v;
		w(5);
		scl_out = 1'b1;
		w(8);
		s = sda_in;
		scl_out = 1'b0;
	endtask
	task start;
		w(3);
		sda_low_out = 1'b0;
		w(5);
		scl_out = 1'b1;
		w(8);
		sda_low_out = 1'b1;
		w(8);
		scl_out = 1'b0;
	endtask
	task stop;
		w(3);
		sda_low_out = 1'b1;
		w(5);
		scl_out = 1'b1;
		w(8);
		sda_low_out = 1'b0;
		w(8);
	endtask
	// Line released in the ninth clock so the slave can answer
	task wbyte(input [7:0] b, output a);
		reg s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		a = !s;
	endtask
endmodule // seeadr_master

/* test/seeadr_slave_props.sv */
// Assertions on the slave front end ports
`timescale 1ns/1ps
module seeadr_slave_props #(
	parameter PROG_CYCLES = 1000000
) (
	input wire       CLK_IN,
	input wire       SYS_RST_IN,
	input wire       SCL_IN,
	input wire       SDA_IN,
	input wire       SDA_OUT,
	input wire       SDA_OE_OUT,
	input wire       WP_IN,
	input wire       ADDR_VALID_OUT,
	input wire       WDATA_VALID_OUT,
	input wire       WDATA_READY_IN,
	input wire [7:0] WDATA_OUT,
	input wire       PROG_BUSY_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	reg [31:0] busy_q;
	always @(posedge CLK_IN)
		busy_q <= (SYS_RST_IN || !PROG_BUSY_OUT) ? 32'h0000_0000 : busy_q + 32'h0000_0001;
	sequence s_start; $fell(SDA_IN) && SCL_IN; endsequence
	sequence s_stop; $rose(SDA_IN) && SCL_IN; endsequence
	sequence s_ack; $rose(SDA_OE_OUT); endsequence
	property p_open; SDA_OUT == 1'b0; endproperty
	property p_len; s_ack |-> SDA_OE_OUT[*8] ##[1:16] !SDA_OE_OUT; endproperty
	property p_edge; ($rose(SDA_OE_OUT) || $fell(SDA_OE_OUT)) |-> !SCL_IN; endproperty
	property p_poll; s_ack |-> !PROG_BUSY_OUT; endproperty
	property p_start; s_start |-> ##[1:6] !ADDR_VALID_OUT; endproperty
	property p_stop; s_stop |-> ##[1:6] !ADDR_VALID_OUT; endproperty
	property p_wp; WP_IN && !PROG_BUSY_OUT |=> !PROG_BUSY_OUT; endproperty
	property p_busy; busy_q <= PROG_CYCLES; endproperty
	property p_hold; WDATA_VALID_OUT && !WDATA_READY_IN |=> WDATA_VALID_OUT && $stable(WDATA_OUT);
	endproperty
	a_open: assert property (p_open) else $error("Data pin driven high");
	a_len: assert property (p_len) else $error("Ack length wrong");
	a_edge: assert property (p_edge) else $error("Ack moved with clock high");
	a_poll: assert property (p_poll) else $error("Ack while busy");
	a_start: assert property (p_start) else $error("Start kept address");
	a_stop: assert property (p_stop) else $error("Stop kept address");
	a_wp: assert property (p_wp) else $error("Program while protected");
	a_busy: assert property (p_busy) else $error("Program cycle too long");
	a_hold: assert property (p_hold) else $error("Stalled word lost");
endmodule // seeadr_slave_props
bind seeadr_slave seeadr_slave_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (.CLK_IN(CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE_OUT(SDA_OE_OUT), .WP_IN(WP_IN), .ADDR_VALID_OUT(ADDR_VALID_OUT),
	.WDATA_VALID_OUT(WDATA_VALID_OUT), .WDATA_READY_IN(WDATA_READY_IN),
	.WDATA_OUT(WDATA_OUT), .PROG_BUSY_OUT(PROG_BUSY_OUT));

/* test/serial_eeprom_i2c_addressing_tb.sv */
// Self-checking bench for the slave front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("Error %s exp %h got %h", n, e, g); end end
module serial_eeprom_i2c_addressing_tb;
	localparam [3:0] TC = 4'h6; // Arbitrary type code
	localparam PC = 400;
	reg clk = 0, rst = 1, rdy = 0, cs = 0, wp = 0, ce = 1;
	wire scl, sl, oe, sda, av, rd, busy, wv, o;
	wire [16:0] addr;
	wire [7:0] wd;
	int errors = 0, cmp_count = 0, cyc = 0;
	reg [31:0] s = 32'h0000_aada;
	reg [7:0] exp_q[$], got_q[$];
	assign sda = !(sl | oe);
	initial forever #5 clk = !clk;
	seeadr_master M (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sl));
	seeadr_slave #(.TYPE_CODE(TC), .PROG_CYCLES(PC)) DUT (.CLK_IN(clk), .SYS_RST_IN(rst),
		.CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(o), .SDA_OE_OUT(oe),
		.CHIP_SELECT_PIN_IN(cs), .WP_IN(wp), .ARRAY_ADDR_OUT(addr), .READ_REQ_OUT(rd),
		.ADDR_VALID_OUT(av), .WDATA_VALID_OUT(wv), .WDATA_READY_IN(rdy), .WDATA_OUT(wd),
		.PROG_BUSY_OUT(busy));
	function [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		xs = s;
	endfunction
	always @(negedge clk) rdy <= (xs() % 3) != 0;
	always @(posedge clk) begin
		cyc++;
		if (wv && rdy && ce) got_q.push_back(wd);
		if (cyc == 60000) begin
			errors++;
			summarize();
		end
	end
	task summarize;
		if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task tr(input [3:0] ty, input b3, input b2, input rw, input int n);
		reg [7:0] hi, lo, d;
		reg a, top, sel, wr, b0;
		top = 1'(xs());
		b0 = busy;
		sel = ty === TC && !b3 && b2 === cs && !b0;
		wr = sel && !rw && !wp && n > 0;
		M.start();
		M.wbyte({ty, b3, b2, top, rw}, a);
		`CHK("sack", sel, a)
		if (sel) begin
			hi = 8'(xs());
			lo = 8'(xs());
			M.wbyte(hi, a);
			`CHK("hack", 1'b1, a)
			M.wbyte(lo, a);
			`CHK("lack", 1'b1, a)
			`CHK("av", 1'b1, av)
			`CHK("addr", {top, hi, lo}, addr)
			`CHK("rd", rw, rd)
			if (n == 0) begin
				M.start();
				`CHK("av1", 1'b0, av)
			end
			repeat (n) begin
				d = 8'(xs());
				M.wbyte(d, a);
				`CHK("dack", !rw && !wp, a)
				if (!rw && !wp) exp_q.push_back(d);
			end
		end
		M.stop();
		if (!b0) `CHK("busy", wr, busy)
		`CHK("av0", 1'b0, av)
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst = 0;
		repeat (3) @(negedge clk);
		repeat (3) begin
			cs = 1'(xs());
			tr(TC, 1'b0, cs, 1'b0, 2);
			tr(TC, 1'b0, cs, 1'b0, 0);
			repeat (PC) @(negedge clk);
			tr(TC ^ 4'h1, 1'b0, cs, 1'b0, 1);
			tr(TC, 1'b1, cs, 1'b0, 1);
			tr(TC, 1'b0, !cs, 1'b0, 1);
			tr(TC, 1'b0, cs, 1'b1, 0);
			wp = 1;
			ce = 0;
			repeat (4) @(negedge clk);
			ce = 1;
			tr(TC, 1'b0, cs, 1'b0, 1);
			wp = 0;
		end
		repeat (20) @(negedge clk);
		`CHK("nwords", exp_q.size(), got_q.size())
		foreach (exp_q[i]) if (i < got_q.size()) `CHK("wdata", exp_q[i], got_q[i])
		summarize();
	end
endmodule // serial_eeprom_i2c_addressing_tb
